// [hdl/tec_consts.vh]
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TEC_ADDR_W 4
`define TEC_OFS_CTRL 4'h0
`define TEC_OFS_PRELOAD_LOW 4'h1
`define TEC_OFS_PRELOAD_HIGH 4'h2
`define TEC_OFS_PRESCALE_SEL 4'h3
`define TEC_OFS_IRQ_STATUS 4'h4
`define TEC_OFS_IRQ_CONTROL 4'h5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TEC_CTRL_RESET 8'h08
`define TEC_ZERO8 8'h00
`define TEC_ZERO16 16'h0000
`define TEC_ALL_ONES16 16'hFFFF

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define TEC_MODE_HI 7
`define TEC_MODE_LO 6
`define TEC_CLK_SRC_BIT 5
`define TEC_ENABLE_BIT 4
`define TEC_EDGE_BIT 3
`define TEC_RATIO_HI 2
`define TEC_RATIO_LO 0

// ---------------------------------------------------------------
// Mode codes and prescale source codes
// ---------------------------------------------------------------
`define TEC_MODE_UNUSED 2'h0
`define TEC_MODE_EVENT 2'h1
`define TEC_MODE_TIMER 2'h2
`define TEC_MODE_PULSE 2'h3
`define TEC_SRC_SYS 2'h0
`define TEC_SRC_SYS_DIV4 2'h1
`define TEC_SRC_LOW_SPEED 2'h2

// ---------------------------------------------------------------
// Status and enable bit position
// ---------------------------------------------------------------
`define TEC_OVF_BIT 0

`endif

// [hdl/tec_timer.v]
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`include "tec_consts.vh"

module tec_timer #(
  parameter CNT_W = 16,
  parameter PSC_W = 11
) (
  clk,
  rst_n,
  addr,
  wdata,
  wr_stb,
  rd_stb,
  rdata,
  low_speed_clock,
  timer_pin,
  irq,
  wake_up
);
  input wire clk;
  input wire rst_n;
  input wire [`TEC_ADDR_W-1:0] addr;
  input wire [7:0] wdata;
  input wire wr_stb;
  input wire rd_stb;
  output reg [7:0] rdata;
  input wire low_speed_clock;
  input wire timer_pin;
  output reg irq;
  output reg wake_up;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Terminal count mask of the prescaler: divide by 16 << ratio
  function [PSC_W-1:0] psc_mask;
    input [2:0] ratio;
    begin
      case (ratio)
        3'h0: psc_mask = 11'h00F;
        3'h1: psc_mask = 11'h01F;
        3'h2: psc_mask = 11'h03F;
        3'h3: psc_mask = 11'h07F;
        3'h4: psc_mask = 11'h0FF;
        3'h5: psc_mask = 11'h1FF;
        3'h6: psc_mask = 11'h3FF;
        default: psc_mask = 11'h7FF;
      endcase
    end
  endfunction

  // Edge of a filtered level in the direction picked by fall
  function edge_hit;
    input prev;
    input cur;
    input fall;
    begin
      edge_hit = fall ? (prev & ~cur) : (~prev & cur);
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [7:0] preload_low_buf_reg;
  reg [CNT_W-1:0] preload_reg;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  reg [7:0] read_low_latch_reg;
  reg [1:0] psc_src_reg;
  reg ovf_flag_reg;
  reg ovf_flag_next;
  reg ovf_en_reg;
  reg pulse_active_reg;
  reg pulse_active_next;
  reg [1:0] div4_reg;
  reg [PSC_W-1:0] psc_cnt_reg;
  reg [2:0] lsc_sync_reg;
  reg lsc_level_reg;
  reg [2:0] pin_sync_reg;
  reg pin_level_reg;
  reg [7:0] rdata_next;
  reg ovf_event;

  wire [1:0] mode = ctrl_reg[`TEC_MODE_HI:`TEC_MODE_LO];
  wire clk_src_sel = ctrl_reg[`TEC_CLK_SRC_BIT];
  wire count_enable = ctrl_reg[`TEC_ENABLE_BIT];
  wire edge_select = ctrl_reg[`TEC_EDGE_BIT];
  wire [2:0] prescale_ratio = ctrl_reg[`TEC_RATIO_HI:`TEC_RATIO_LO];

  wire wr_ctrl = wr_stb && (addr == `TEC_OFS_CTRL);
  wire wr_high = wr_stb && (addr == `TEC_OFS_PRELOAD_HIGH);
  wire rd_high = rd_stb && (addr == `TEC_OFS_PRELOAD_HIGH);
  wire rd_status = rd_stb && (addr == `TEC_OFS_IRQ_STATUS);

  // ---------------------------------------------------------------
  // Pin input filters
  // ---------------------------------------------------------------
  // Three stages; level moves only once stages two and three agree
  wire lsc_stable = (lsc_sync_reg[1] == lsc_sync_reg[2]);
  wire lsc_new = lsc_stable ? lsc_sync_reg[2] : lsc_level_reg;
  wire lsc_fall = lsc_level_reg & ~lsc_new;
  wire pin_stable = (pin_sync_reg[1] == pin_sync_reg[2]);
  wire pin_new = pin_stable ? pin_sync_reg[2] : pin_level_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      lsc_sync_reg <= 3'h0;
      lsc_level_reg <= 1'b0;
      pin_sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      lsc_sync_reg <= {lsc_sync_reg[1:0], low_speed_clock};
      lsc_level_reg <= lsc_new;
      pin_sync_reg <= {pin_sync_reg[1:0], timer_pin};
      pin_level_reg <= pin_new;
    end
  end

  // ---------------------------------------------------------------
  // Counting clock selection
  // ---------------------------------------------------------------
  // Source clocks are carried as one-cycle ticks on clk, which keeps
  // the whole block in one domain at the cost of a jitter of one clk
  reg psc_in_tick;
  always @* begin
    case (psc_src_reg)
      `TEC_SRC_SYS: psc_in_tick = 1'b1;
      `TEC_SRC_SYS_DIV4: psc_in_tick = (div4_reg == 2'h3);
      `TEC_SRC_LOW_SPEED: psc_in_tick = lsc_fall;
      default: psc_in_tick = 1'b0;
    endcase
  end

  // The divided clock falls as the prescaler wraps at its mask
  wire psc_fall = psc_in_tick &&
    ((psc_cnt_reg & psc_mask(prescale_ratio)) ==
     psc_mask(prescale_ratio));
  wire int_tick = clk_src_sel ? lsc_fall : psc_fall;

  always @(posedge clk) begin
    if (!rst_n) begin
      div4_reg <= 2'h0;
      psc_cnt_reg <= {PSC_W{1'b0}};
    end else begin
      div4_reg <= div4_reg + 2'h1;
      if (psc_in_tick)
        psc_cnt_reg <= psc_cnt_reg + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Mode logic
  // ---------------------------------------------------------------
  // Pulse mode: the start edge opposes the edge select, stop follows it
  wire pin_start = edge_hit(pin_level_reg, pin_new, ~edge_select);
  wire pin_stop = edge_hit(pin_level_reg, pin_new, edge_select);
  wire pin_event = edge_hit(pin_level_reg, pin_new, edge_select);

  reg cnt_tick;
  reg pulse_done;
  always @* begin
    cnt_tick = 1'b0;
    pulse_done = 1'b0;
    pulse_active_next = pulse_active_reg;
    if (count_enable) begin
      case (mode)
        `TEC_MODE_TIMER: cnt_tick = int_tick;
        `TEC_MODE_EVENT: cnt_tick = pin_event;
        `TEC_MODE_PULSE: begin
          if (pulse_active_reg) begin
            cnt_tick = int_tick;
            if (pin_stop) begin
              pulse_active_next = 1'b0;
              pulse_done = 1'b1;
            end
          end else if (pin_start) begin
            pulse_active_next = 1'b1;
          end
        end
        default: cnt_tick = 1'b0;
      endcase
    end else begin
      pulse_active_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Counter and overflow
  // ---------------------------------------------------------------
  always @* begin
    count_next = count_reg;
    ovf_event = 1'b0;
    if (cnt_tick) begin
      if (count_reg == `TEC_ALL_ONES16) begin
        count_next = preload_reg;
        ovf_event = 1'b1;
      end else begin
        count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Overflow flag: a new overflow wins over a clearing read
  always @* begin
    ovf_flag_next = ovf_flag_reg;
    if (rd_status)
      ovf_flag_next = 1'b0;
    if (ovf_event)
      ovf_flag_next = 1'b1;
  end

  // Control: software write, then hardware clear of enable after a pulse
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = wdata;
    else if (pulse_done)
      ctrl_next[`TEC_ENABLE_BIT] = 1'b0;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= `TEC_CTRL_RESET;
      count_reg <= `TEC_ZERO16;
      ovf_flag_reg <= 1'b0;
      pulse_active_reg <= 1'b0;
      wake_up <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      count_reg <= count_next;
      ovf_flag_reg <= ovf_flag_next;
      pulse_active_reg <= pulse_active_next;
      wake_up <= ovf_event;
      irq <= ovf_flag_next & ovf_en_reg;
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      preload_low_buf_reg <= `TEC_ZERO8;
      preload_reg <= `TEC_ZERO16;
      read_low_latch_reg <= `TEC_ZERO8;
      psc_src_reg <= `TEC_SRC_SYS;
      ovf_en_reg <= 1'b0;
    end else begin
      if (wr_stb && (addr == `TEC_OFS_PRELOAD_LOW))
        preload_low_buf_reg <= wdata;
      if (wr_high)
        preload_reg <= {wdata, preload_low_buf_reg};
      if (wr_stb && (addr == `TEC_OFS_PRESCALE_SEL))
        psc_src_reg <= wdata[1:0];
      if (wr_stb && (addr == `TEC_OFS_IRQ_CONTROL))
        ovf_en_reg <= wdata[`TEC_OVF_BIT];
      // Reading the high byte snapshots the low byte for a coherent pair
      if (rd_high)
        read_low_latch_reg <= count_reg[7:0];
    end
  end

  always @* begin
    rdata_next = `TEC_ZERO8;
    if (rd_stb) begin
      case (addr)
        `TEC_OFS_CTRL: rdata_next = ctrl_reg;
        `TEC_OFS_PRELOAD_LOW: rdata_next = read_low_latch_reg;
        `TEC_OFS_PRELOAD_HIGH: rdata_next = count_reg[15:8];
        `TEC_OFS_PRESCALE_SEL: rdata_next = {6'h00, psc_src_reg};
        `TEC_OFS_IRQ_STATUS: rdata_next = {7'h00, ovf_flag_reg};
        `TEC_OFS_IRQ_CONTROL: rdata_next = {7'h00, ovf_en_reg};
        default: rdata_next = `TEC_ZERO8;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n)
      rdata <= `TEC_ZERO8;
    else
      rdata <= rdata_next;
  end

endmodule // tec_timer

// [tb/tec_timer_properties.sv]
`timescale 1ns/100ps
`include "tec_consts.vh"
module tec_timer_chk (
  input wire clk,
  input wire rst_n,
  input wire [`TEC_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire low_speed_clock,
  input wire timer_pin,
  input wire irq,
  input wire wake_up
);
  // ---------------------------------------------------------------
  // Shadows; pulse-mode auto-clear is ignored as it only stops counts and clears bit 4, which the read check skips
  // ---------------------------------------------------------------
  reg [7:0] ctl_reg;
  reg ien_reg;
  wire st_rd = rd_stb && addr == `TEC_OFS_IRQ_STATUS;
  wire ie_wr = wr_stb && addr == `TEC_OFS_IRQ_CONTROL;
  wire run = ctl_reg[7:6] != `TEC_MODE_UNUSED && ctl_reg[4];
  always @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg <= `TEC_CTRL_RESET;
      ien_reg <= 1'b0;
    end else begin
      if (wr_stb && addr == `TEC_OFS_CTRL)
        ctl_reg <= wdata;
      if (ie_wr)
        ien_reg <= wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wake_pulse; wake_up |=> !wake_up; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake_up wider than one cycle");
  property p_wake_run; wake_up |-> run || $past(run); endproperty
  a_wake_run: assert property (p_wake_run)
    else $error("overflow while stopped");
  property p_wake_irq; wake_up && ien_reg && $past(ien_reg) |-> irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("no irq on enabled overflow");
  property p_irq_en; irq |-> ien_reg || $past(ien_reg); endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("irq while masked");
  property p_irq_rise;
    $rose(irq) |-> wake_up || $past(ie_wr) || $past(ie_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) |-> $past(st_rd) || $past(st_rd, 2)
    || $past(ie_wr) || $past(ie_wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without clear");
  property p_status_fmt; $past(st_rd) |-> rdata[7:1] == 7'h00; endproperty
  a_status_fmt: assert property (p_status_fmt)
    else $error("status upper bits set");
  property p_ctrl_read; $past(rd_stb && addr == `TEC_OFS_CTRL) |->
    {rdata[7:5], rdata[3:0]} == {$past(ctl_reg[7:5]), $past(ctl_reg[3:0])};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control readback wrong");
endmodule // tec_timer_chk
bind tec_timer tec_timer_chk i_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .low_speed_clock(low_speed_clock), .timer_pin(timer_pin), .irq(irq),
  .wake_up(wake_up));

// [tb/tec_timer_tb.sv]
`timescale 1ns/100ps
`include "tec_consts.vh"
module tec_timer_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [`TEC_ADDR_W-1:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg low_speed_clock = 1'b0;
  reg timer_pin = 1'b0;
  reg [1:0] ls_div = 2'h0;
  wire [7:0] rdata;
  wire irq;
  wire wake_up;
  integer fail_count = 0;
  integer checks = 0;
  integer n;
  integer r;
  reg [7:0] d;
  reg [15:0] c0;
  reg [15:0] c1;
  tec_timer i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .low_speed_clock(low_speed_clock), .timer_pin(timer_pin), .irq(irq),
    .wake_up(wake_up));
  initial begin
    forever #4 clk = ~clk;
  end
  // Low-speed clock free-runs at a quarter of clk: one tick per 4 cycles
  always @(posedge clk) begin
    ls_div <= ls_div + 2'h1;
    low_speed_clock <= ls_div[1];
  end
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] v);
    begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      v = rdata;
    end
  endtask
  task rdc(output [15:0] c);
    reg [7:0] h;
    reg [7:0] l;
    begin
      rd(`TEC_OFS_PRELOAD_HIGH, h);
      rd(`TEC_OFS_PRELOAD_LOW, l);
      c = {h, l};
    end
  endtask
  // Latch edges of the two count reads lie exactly cyc cycles apart
  task meas(input [7:0] ctl, input integer cyc, input [15:0] exp);
    begin
      wr(`TEC_OFS_CTRL, ctl);
      rdc(c0);
      repeat (cyc - 4) @(posedge clk);
      rdc(c1);
      chk(c1 - c0, exp);
    end
  endtask
  // Pin level v for len cycles, then back, then settle past the filter
  task pulse_pin(input v, input integer len);
    begin
      @(posedge clk);
      timer_pin <= v;
      repeat (len) @(posedge clk);
      timer_pin <= ~v;
      repeat (8) @(posedge clk);
    end
  endtask
  task wait_wake(input integer lim);
    begin
      @(negedge clk);
      n = 1;
      while (wake_up !== 1'b1 && n < lim) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= lim)
        chk(16'h0000, 16'h0001);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (400000) @(posedge clk);
    fail_count = fail_count + 1;
    close_out;
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TEC_OFS_CTRL, d);
    chk({8'h00, d}, 16'h0008);
    rd(`TEC_OFS_IRQ_STATUS, d);
    chk({8'h00, d}, 16'h0000);
    rd(`TEC_OFS_IRQ_CONTROL, d);
    chk({8'h00, d}, 16'h0000);
    wr(4'h9, 8'hFF);
    rd(4'h9, d);
    chk({8'h00, d}, 16'h0000);
    $display("test reset done");
    wr(`TEC_OFS_PRESCALE_SEL, 8'h00);
    for (r = 0; r < 8; r = r + 1)
      meas(8'h90 + r[7:0], 64 << r, 16'h0004);
    rd(`TEC_OFS_CTRL, d);
    chk({8'h00, d}, 16'h0097);
    for (r = 1; r < 4; r = r + 1) begin
      wr(`TEC_OFS_PRESCALE_SEL, r[7:0]);
      meas(8'h90, 256, (r == 3) ? 16'h0000 : 16'h0004);
    end
    meas(8'hB0, 64, 16'h0010);
    meas(8'hA0, 64, 16'h0000);
    meas(8'h30, 64, 16'h0000);
    $display("test rates done");
    wr(`TEC_OFS_CTRL, 8'h50);
    rdc(c0);
    pulse_pin(1'b1, 8);
    rdc(c1);
    chk(c1 - c0, 16'h0001);
    wr(`TEC_OFS_CTRL, 8'h58);
    rdc(c0);
    pulse_pin(1'b1, 8);
    rdc(c1);
    chk(c1 - c0, 16'h0001);
    wr(`TEC_OFS_CTRL, 8'hF0);
    @(posedge clk);
    timer_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(c0);
    pulse_pin(1'b0, 64);
    rdc(c1);
    chk(c1 - c0, 16'h0010);
    rd(`TEC_OFS_CTRL, d);
    chk({8'h00, d}, 16'h00E0);
    $display("test pin modes done");
    wr(`TEC_OFS_PRELOAD_LOW, 8'hFC);
    wr(`TEC_OFS_PRELOAD_HIGH, 8'hFF);
    wr(`TEC_OFS_IRQ_CONTROL, 8'h01);
    wr(`TEC_OFS_CTRL, 8'hB0);
    wait_wake(300000);
    chk({15'h0000, irq}, 16'h0001);
    wait_wake(40);
    chk(n[15:0], 16'h0010);
    wr(`TEC_OFS_CTRL, 8'hA0);
    rd(`TEC_OFS_IRQ_STATUS, d);
    chk({8'h00, d}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    rd(`TEC_OFS_IRQ_STATUS, d);
    chk({8'h00, d}, 16'h0000);
    wr(`TEC_OFS_IRQ_CONTROL, 8'h00);
    wr(`TEC_OFS_CTRL, 8'hB0);
    wait_wake(100);
    wr(`TEC_OFS_CTRL, 8'hA0);
    chk({15'h0000, irq}, 16'h0000);
    rd(`TEC_OFS_IRQ_STATUS, d);
    chk({8'h00, d}, 16'h0001);
    $display("test overflow done");
    close_out;
  end
endmodule // tec_timer_tb
